// *** crs_pkg.sv ***
// Purpose: Shared constants for the core reset state initialiser.
// Assumes: 32-bit registers, one aligned word each, byte addresses below.
// Notes:   Field positions count from the least significant bit.
package crs_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int         REG_AW    = 8;
	localparam logic [7:0] OFF_MSW   = 8'h00;
	localparam logic [7:0] OFF_DBC   = 8'h04;
	localparam logic [7:0] OFF_DBS   = 8'h08;
	localparam logic [7:0] OFF_TCR   = 8'h0c;
	localparam logic [7:0] OFF_TSR   = 8'h10;
	localparam logic [7:0] OFF_PVR   = 8'h14;
	localparam logic [7:0] OFF_CC0   = 8'h18;
	localparam logic [7:0] OFF_CC1   = 8'h1c;
	localparam logic [7:0] OFF_ESR   = 8'h20;
	localparam logic [7:0] OFF_MCS   = 8'h24;
	localparam logic [7:0] OFF_RCF   = 8'h28;
	localparam logic [31:0] REG_ZERO = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DC_RST_LO  = 28;
	localparam int DS_EVT_LO  = 0;
	localparam int DS_EVT_W   = 15;
	localparam int DS_KIND_LO = 28;
	localparam int TC_WRC_LO  = 30;
	localparam int TS_WRS_LO  = 28;
	localparam int ES_MCI     = 31;
	localparam int MC_MCS     = 31;
	localparam int RC_UA_LO   = 28;
	localparam int RC_E       = 27;
	localparam int RC_EP_LO   = 0;
	localparam int UATTR_W    = 4;

	// ----------------------------------------------------------------
	// Reset kinds and access kinds
	// ----------------------------------------------------------------
	localparam logic [1:0] KIND_NONE = 2'h0;
	localparam logic [1:0] KIND_CORE = 2'h1;
	localparam logic [1:0] KIND_CHIP = 2'h2;
	localparam logic [1:0] KIND_SYS  = 2'h3;
	localparam logic [1:0] ACC_FETCH = 2'h0;
	localparam logic [1:0] ACC_READ  = 2'h1;
	localparam logic [1:0] ACC_WRITE = 2'h2;

	// ----------------------------------------------------------------
	// Reset shadow translation entry and fetch address
	// ----------------------------------------------------------------
	localparam logic [31:0] FETCH_RESET_EA = 32'hffff_fffc;
	localparam int          PAGE_SHIFT     = 12;
	localparam logic [19:0] SH_EPN         = 20'hfffff;
	localparam logic [19:0] SH_RPN_HI      = 20'hfffff;
	localparam logic [1:0]  SH_RPN_LO      = 2'h0;
	localparam logic [3:0]  SH_SIZE        = 4'h1;
	localparam logic        SH_TS          = 1'h0;
	localparam logic [7:0]  SH_TID         = 8'h00;
	localparam logic        SH_W           = 1'h0;
	localparam logic        SH_I           = 1'h1;
	localparam logic        SH_M           = 1'h0;
	localparam logic        SH_G           = 1'h1;
	localparam logic        SH_SX          = 1'h1;
	localparam logic        SH_SW          = 1'h0;
	localparam logic        SH_SR          = 1'h1;

	// ----------------------------------------------------------------
	// Bus responses
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** crs_sync.sv ***
// Purpose: Two-stage synchroniser for a bundle of pin inputs.
// Assumes: Each bit is an independent slow level.
// Notes:   Not reset, so it keeps tracking the pins during reset.
module crs_sync
	import crs_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} crs_sync_s;

	crs_sync_s st_r;
	crs_sync_s st_nxt;

	// First stage feeds only the second stage
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end

	// State register
	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

	assign q = st_r.s2;

endmodule

// *** crs_axil.sv ***
// Purpose: AXI4-Lite slave front end for the register file.
// Assumes: One write and one read in flight at most.
// Notes:   Address and data of a write may arrive in either order.
module crs_axil
	import crs_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [REG_AW-1:0] s_awaddr,
	input  wire logic              s_awvalid,
	output logic                   s_awready,
	input  wire logic [31:0]       s_wdata,
	input  wire logic [3:0]        s_wstrb,
	input  wire logic              s_wvalid,
	output logic                   s_wready,
	output logic [1:0]             s_bresp,
	output logic                   s_bvalid,
	input  wire logic              s_bready,
	input  wire logic [REG_AW-1:0] s_araddr,
	input  wire logic              s_arvalid,
	output logic                   s_arready,
	output logic [31:0]            s_rdata,
	output logic [1:0]             s_rresp,
	output logic                   s_rvalid,
	input  wire logic              s_rready,
	output logic                   wr_stb,
	output logic [REG_AW-1:0]      wr_addr,
	output logic [31:0]            wr_data,
	output logic [3:0]             wr_strb,
	input  wire logic              wr_err,
	output logic [REG_AW-1:0]      rd_addr,
	input  wire logic [31:0]       rd_data,
	input  wire logic              rd_err
);

	typedef struct packed {
		logic              aw_got;
		logic              w_got;
		logic [REG_AW-1:0] addr;
		logic [31:0]       data;
		logic [3:0]        strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} crs_axil_s;

	crs_axil_s st_r;
	crs_axil_s st_nxt;

	// Handshake outputs
	assign s_awready = !st_r.aw_got && !st_r.bvalid;
	assign s_wready  = !st_r.w_got && !st_r.bvalid;
	assign s_arready = !st_r.rvalid;
	assign wr_stb    = st_r.aw_got && st_r.w_got && !st_r.bvalid;
	assign wr_addr   = st_r.addr;
	assign wr_data   = st_r.data;
	assign wr_strb   = st_r.strb;
	assign rd_addr   = s_araddr;
	assign s_bvalid  = st_r.bvalid;
	assign s_bresp   = st_r.bresp;
	assign s_rvalid  = st_r.rvalid;
	assign s_rdata   = st_r.rdata;
	assign s_rresp   = st_r.rresp;

	// Channel bookkeeping
	always_comb begin
		st_nxt = st_r;
		if (s_awvalid && s_awready) begin
			st_nxt.aw_got = 1'b1;
			st_nxt.addr   = s_awaddr;
		end
		if (s_wvalid && s_wready) begin
			st_nxt.w_got = 1'b1;
			st_nxt.data  = s_wdata;
			st_nxt.strb  = s_wstrb;
		end
		if (wr_stb) begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got  = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp  = wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (st_r.bvalid && s_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (s_arvalid && s_arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata  = rd_data;
			st_nxt.rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		if (st_r.rvalid && s_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (rst) begin
			st_nxt = '0;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

endmodule

// *** crs_core_init.sv ***
// Purpose: Core reset state, reset kind record and reset shadow entry.
// Assumes: rst held at least three clocks so synchronised pins settle.
// Notes:   Pins pass two flops; core-side event inputs are same clock.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
module crs_core_init
	import crs_pkg::*;
#(
	parameter int MAKER_W = 12,
	parameter int VER_W   = 20,
	parameter int EXTENDED_REAL_PAGE_W  = 4
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [REG_AW-1:0] s_awaddr,
	input  wire logic              s_awvalid,
	output logic                   s_awready,
	input  wire logic [31:0]       s_wdata,
	input  wire logic [3:0]        s_wstrb,
	input  wire logic              s_wvalid,
	output logic                   s_wready,
	output logic [1:0]             s_bresp,
	output logic                   s_bvalid,
	input  wire logic              s_bready,
	input  wire logic [REG_AW-1:0] s_araddr,
	input  wire logic              s_arvalid,
	output logic                   s_arready,
	output logic [31:0]            s_rdata,
	output logic [1:0]             s_rresp,
	output logic                   s_rvalid,
	input  wire logic              s_rready,
	input  wire logic              kind_core_pin,
	input  wire logic              kind_chip_pin,
	input  wire logic              kind_sys_pin,
	input  wire logic              wdog_cause_pin,
	input  wire logic              power_up_pin,
	input  wire logic [MAKER_W-1:0] maker_code_pin,
	input  wire logic [VER_W-1:0]  version_number_code_pin,
	input  wire logic [UATTR_W-1:0] cfg_user_attr_pin,
	input  wire logic              cfg_endian_pin,
	input  wire logic [EXTENDED_REAL_PAGE_W-1:0] cfg_ext_page_pin,
	input  wire logic              ctx_sync,
	input  wire logic [DS_EVT_W-1:0] dbg_event,
	input  wire logic              sync_mchk_evt,
	input  wire logic              async_mchk_evt,
	input  wire logic              acc_valid,
	input  wire logic [31:0]       acc_ea,
	input  wire logic [1:0]        acc_kind,
	output logic                   acc_ok,
	output logic [31:0]            reset_fetch_addr,
	output logic                   instr_shadow_valid,
	output logic                   data_shadow_valid,
	output logic [19:0]            sh_epn,
	output logic [21:0]            sh_rpn,
	output logic [EXTENDED_REAL_PAGE_W-1:0]      sh_extended_real_page,
	output logic [3:0]             sh_size,
	output logic                   sh_ts,
	output logic [7:0]             sh_tid,
	output logic [UATTR_W-1:0]     sh_user_attr,
	output logic [4:0]             sh_wimge,
	output logic [2:0]             sh_perm,
	output logic [31:0]            msw_out,
	output logic [1:0]             soft_reset_req,
	output logic [1:0]             wdog_reset_ctrl,
	output logic [31:0]            core_cfg0_out,
	output logic [31:0]            core_cfg1_out
);

	localparam int SYNC_W = 5 + MAKER_W + VER_W + UATTR_W + 1 + EXTENDED_REAL_PAGE_W;

	typedef struct packed {
		logic [31:0] msw;
		logic [31:0] dbc;
		logic [31:0] dbs;
		logic [31:0] timer_control_word;
		logic [31:0] timer_status_word;
		logic [31:0] processor_version_word;
		logic [31:0] cc0;
		logic [31:0] cc1;
		logic [31:0] exception_syndrome_word;
		logic [31:0] async_instr_check_flag;
		logic [31:0] rcf;
		logic [31:0] pc;
		logic        in_rst;
		logic [1:0]  sh_v;
	} crs_main_s;

	crs_main_s st_r;
	crs_main_s st_nxt;

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0]  pin_sync;
	logic               kc_s;
	logic               kp_s;
	logic               ks_s;
	logic               wd_s;
	logic               pu_s;
	logic [MAKER_W-1:0] maker_s;
	logic [VER_W-1:0]   ver_s;
	logic [UATTR_W-1:0] ua_s;
	logic               en_s;
	logic [EXTENDED_REAL_PAGE_W-1:0]  ep_s;

	crs_sync #(.W(SYNC_W)) u_sync (
		.clk (clk),
		.d   ({kind_core_pin, kind_chip_pin, kind_sys_pin, wdog_cause_pin, power_up_pin,
			maker_code_pin, version_number_code_pin, cfg_user_attr_pin, cfg_endian_pin,
			cfg_ext_page_pin}),
		.q   (pin_sync)
	);

	assign {kc_s, kp_s, ks_s, wd_s, pu_s, maker_s, ver_s, ua_s, en_s, ep_s} = pin_sync;

	// ----------------------------------------------------------------
	// Bus front end
	// ----------------------------------------------------------------
	logic              wr_stb;
	logic [REG_AW-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic              wr_err;
	logic [REG_AW-1:0] rd_addr;
	logic [31:0]       rd_data;
	logic              rd_err;

	crs_axil u_axil (
		.clk       (clk),
		.rst       (rst),
		.s_awaddr  (s_awaddr),
		.s_awvalid (s_awvalid),
		.s_awready (s_awready),
		.s_wdata   (s_wdata),
		.s_wstrb   (s_wstrb),
		.s_wvalid  (s_wvalid),
		.s_wready  (s_wready),
		.s_bresp   (s_bresp),
		.s_bvalid  (s_bvalid),
		.s_bready  (s_bready),
		.s_araddr  (s_araddr),
		.s_arvalid (s_arvalid),
		.s_arready (s_arready),
		.s_rdata   (s_rdata),
		.s_rresp   (s_rresp),
		.s_rvalid  (s_rvalid),
		.s_rready  (s_rready),
		.wr_stb    (wr_stb),
		.wr_addr   (wr_addr),
		.wr_data   (wr_data),
		.wr_strb   (wr_strb),
		.wr_err    (wr_err),
		.rd_addr   (rd_addr),
		.rd_data   (rd_data),
		.rd_err    (rd_err)
	);

	// Byte-lane merge of a write into an old value
	function automatic logic [31:0] crs_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sb[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Decode of mapped offsets
	function automatic logic crs_mapped(input logic [REG_AW-1:0] a);
		case (a)
			OFF_MSW, OFF_DBC, OFF_DBS, OFF_TCR, OFF_TSR, OFF_PVR,
			OFF_CC0, OFF_CC1, OFF_ESR, OFF_MCS, OFF_RCF: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	assign wr_err = !crs_mapped(wr_addr);

	// Read data mux
	always_comb begin
		rd_err = !crs_mapped(rd_addr);
		case (rd_addr)
			OFF_MSW: rd_data = st_r.msw;
			OFF_DBC: rd_data = st_r.dbc;
			OFF_DBS: rd_data = st_r.dbs;
			OFF_TCR: rd_data = st_r.timer_control_word;
			OFF_TSR: rd_data = st_r.timer_status_word;
			OFF_PVR: rd_data = st_r.processor_version_word;
			OFF_CC0: rd_data = st_r.cc0;
			OFF_CC1: rd_data = st_r.cc1;
			OFF_ESR: rd_data = st_r.exception_syndrome_word;
			OFF_MCS: rd_data = st_r.async_instr_check_flag;
			OFF_RCF: rd_data = st_r.rcf;
			default: rd_data = REG_ZERO;
		endcase
	end

	// ----------------------------------------------------------------
	// Reset kind and register state
	// ----------------------------------------------------------------
	logic [1:0]  kind_code;
	logic [31:0] wmask;

	// System outranks chip, chip outranks core
	always_comb begin
		if (ks_s) begin
			kind_code = KIND_SYS;
		end else if (kp_s) begin
			kind_code = KIND_CHIP;
		end else if (kc_s) begin
			kind_code = KIND_CORE;
		end else begin
			kind_code = KIND_NONE;
		end
	end

	assign wmask = crs_merge(REG_ZERO, wr_data, wr_strb);

	// Next state: reset image, software writes, hardware events
	always_comb begin
		st_nxt     = st_r;
		st_nxt.processor_version_word = 32'({maker_s, ver_s});
		if (rst) begin
			st_nxt.msw    = REG_ZERO;
			st_nxt.dbc    = REG_ZERO;
			st_nxt.timer_control_word    = REG_ZERO;
			st_nxt.cc0    = REG_ZERO;
			st_nxt.cc1    = REG_ZERO;
			st_nxt.exception_syndrome_word    = REG_ZERO;
			st_nxt.async_instr_check_flag    = REG_ZERO;
			st_nxt.dbs    = REG_ZERO;
			st_nxt.dbs[DS_KIND_LO +: 2] = kind_code;
			st_nxt.pc     = FETCH_RESET_EA;
			st_nxt.sh_v   = 2'h3;
			st_nxt.rcf    = REG_ZERO;
			st_nxt.rcf[RC_UA_LO +: UATTR_W] = ua_s;
			st_nxt.rcf[RC_E]                = en_s;
			st_nxt.rcf[RC_EP_LO +: EXTENDED_REAL_PAGE_W]  = ep_s;
			// Power-up scrubs status in every reset cycle; first cycle sees old control
			if (pu_s) begin
				st_nxt.timer_status_word = REG_ZERO;
			end else if (!st_r.in_rst && wd_s) begin
				st_nxt.timer_status_word[TS_WRS_LO +: 2] = st_r.timer_control_word[TC_WRC_LO +: 2];
			end
			st_nxt.in_rst = 1'b1;
		end else begin
			st_nxt.in_rst = 1'b0;
			if (wr_stb) begin
				case (wr_addr)
					OFF_MSW: st_nxt.msw = crs_merge(st_r.msw, wr_data, wr_strb);
					OFF_DBC: st_nxt.dbc = crs_merge(st_r.dbc, wr_data, wr_strb);
					OFF_TCR: st_nxt.timer_control_word = crs_merge(st_r.timer_control_word, wr_data, wr_strb);
					OFF_CC0: st_nxt.cc0 = crs_merge(st_r.cc0, wr_data, wr_strb);
					OFF_CC1: st_nxt.cc1 = crs_merge(st_r.cc1, wr_data, wr_strb);
					OFF_DBS: st_nxt.dbs = st_r.dbs & ~wmask;
					OFF_ESR: st_nxt.exception_syndrome_word = st_r.exception_syndrome_word & ~wmask;
					OFF_MCS: st_nxt.async_instr_check_flag = st_r.async_instr_check_flag & ~wmask;
					default: st_nxt.msw = st_r.msw;
				endcase
			end
			// Events land after the clear so a set wins
			st_nxt.dbs[DS_EVT_LO +: DS_EVT_W] = st_nxt.dbs[DS_EVT_LO +: DS_EVT_W] | dbg_event;
			st_nxt.exception_syndrome_word[ES_MCI] = st_nxt.exception_syndrome_word[ES_MCI] | sync_mchk_evt;
			st_nxt.async_instr_check_flag[MC_MCS] = st_nxt.async_instr_check_flag[MC_MCS] | async_mchk_evt;
			if (ctx_sync) begin
				st_nxt.sh_v = 2'h0;
			end
		end
	end

	// State register
	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

	// ----------------------------------------------------------------
	// Shadow entry and outputs
	// ----------------------------------------------------------------
	assign reset_fetch_addr   = st_r.pc;
	assign instr_shadow_valid = st_r.sh_v[0];
	assign data_shadow_valid  = st_r.sh_v[1];
	assign sh_epn       = SH_EPN;
	assign sh_rpn       = {SH_RPN_HI, SH_RPN_LO};
	assign sh_size      = SH_SIZE;
	assign sh_ts        = SH_TS;
	assign sh_tid       = SH_TID;
	assign sh_extended_real_page      = st_r.rcf[RC_EP_LO +: EXTENDED_REAL_PAGE_W];
	assign sh_user_attr = st_r.rcf[RC_UA_LO +: UATTR_W];
	assign sh_wimge     = {SH_W, SH_I, SH_M, SH_G, st_r.rcf[RC_E]};
	assign sh_perm      = {SH_SX, SH_SW, SH_SR};
	assign msw_out         = st_r.msw;
	assign soft_reset_req  = st_r.dbc[DC_RST_LO +: 2];
	assign wdog_reset_ctrl = st_r.timer_control_word[TC_WRC_LO +: 2];
	assign core_cfg0_out   = st_r.cc0;
	assign core_cfg1_out   = st_r.cc1;

	// Page hit and permission check
	always_comb begin
		acc_ok = 1'b0;
		if (acc_valid && acc_ea[31:PAGE_SHIFT] == SH_EPN) begin
			case (acc_kind)
				ACC_FETCH: acc_ok = st_r.sh_v[0] && SH_SX;
				ACC_READ:  acc_ok = st_r.sh_v[1] && SH_SR;
				ACC_WRITE: acc_ok = st_r.sh_v[1] && SH_SW;
				default:   acc_ok = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_release;
		$fell(rst);
	endsequence

	property p_msw_clear;
		s_release |-> st_r.msw == REG_ZERO && msw_out == REG_ZERO;
	endproperty
	a_msw_clear: assert property (p_msw_clear) else $error("state word not clear");

	property p_soft_rst_clear;
		s_release |-> soft_reset_req == 2'h0 && st_r.dbc == REG_ZERO;
	endproperty
	a_soft_rst_clear: assert property (p_soft_rst_clear) else $error("debug reset set");

	property p_kind;
		s_release |-> st_r.dbs[DS_KIND_LO +: 2] == $past(kind_code);
	endproperty
	a_kind: assert property (p_kind) else $error("reset kind wrong");

	property p_wrc_clear;
		s_release |-> wdog_reset_ctrl == 2'h0;
	endproperty
	a_wrc_clear: assert property (p_wrc_clear) else $error("watchdog control set");

	property p_version;
		st_r.processor_version_word == $past(32'({maker_s, ver_s}));
	endproperty
	a_version: assert property (p_version) else $error("version word stale");

	property p_fetch;
		s_release |-> reset_fetch_addr == FETCH_RESET_EA;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch address wrong");

	property p_no_write;
		acc_valid && acc_kind == ACC_WRITE |-> !acc_ok;
	endproperty
	a_no_write: assert property (p_no_write) else $error("write allowed");

	property p_shadow_valid;
		s_release ##0 !ctx_sync |=> instr_shadow_valid && data_shadow_valid;
	endproperty
	a_shadow_valid: assert property (p_shadow_valid) else $error("shadow entry lost");

	property p_extended_real_page;
		s_release |-> sh_extended_real_page == $past(ep_s) && sh_user_attr == $past(ua_s);
	endproperty
	a_extended_real_page: assert property (p_extended_real_page) else $error("captured config wrong");

	property p_invalidate;
		ctx_sync |=> !instr_shadow_valid && !data_shadow_valid ##1 !acc_ok || acc_kind != ACC_READ;
	endproperty
	a_invalidate: assert property (p_invalidate) else $error("shadow not invalidated");

	property p_mchk_set;
		sync_mchk_evt |=> st_r.exception_syndrome_word[ES_MCI] [*1];
	endproperty
	a_mchk_set: assert property (p_mchk_set) else $error("machine check flag lost");

endmodule

// *** crs_pins_model.sv ***
// Purpose: Chip-level reset kind and cause pins.
// Assumes: Bench picks the kind; levels held across reset.
// Notes:   Kind code 0 drives no kind pin.
module crs_pins_model
	import crs_pkg::*;
(
	input  wire logic [1:0] kind_sel,
	input  wire logic       wd,
	input  wire logic       pu,
	output logic            kind_core_pin,
	output logic            kind_chip_pin,
	output logic            kind_sys_pin,
	output logic            wdog_cause_pin,
	output logic            power_up_pin
);
	timeunit 1ns;
	timeprecision 1ns;

	// One-hot kind select, cause flags passed through
	assign kind_core_pin  = kind_sel == KIND_CORE;
	assign kind_chip_pin  = kind_sel == KIND_CHIP;
	assign kind_sys_pin   = kind_sel == KIND_SYS;
	assign wdog_cause_pin = wd;
	assign power_up_pin   = pu;
endmodule

// *** tb_top.sv ***
// Purpose: Self-checking bench for the core reset initialiser.
// Assumes: Reads answer in order, rready and bready held high.
// Notes:   Each reset kind is run after dirtying the registers.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import crs_pkg::*;
	logic clk = 0, rst = 1, s_awvalid = 0, s_wvalid = 0, s_arvalid = 0, s_bready = 1, s_rready = 1;
	logic [7:0] s_awaddr = 0, s_araddr = 0;
	logic [31:0] s_wdata = 0, acc_ea = 0, s_rdata, reset_fetch_addr, msw_out, core_cfg0_out;
	logic [31:0] core_cfg1_out;
	logic [3:0] s_wstrb = 4'hf, cfg_user_attr_pin = 0, cfg_ext_page_pin = 0, sh_extended_real_page, sh_size;
	logic [3:0] sh_user_attr;
	logic [1:0] s_bresp, s_rresp, soft_reset_req, wdog_reset_ctrl, acc_kind = 0, kind_sel = 0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, acc_ok, sh_ts, wd = 0, pu = 0;
	logic kind_core_pin, kind_chip_pin, kind_sys_pin, wdog_cause_pin, power_up_pin;
	logic cfg_endian_pin = 0, ctx_sync = 0, sync_mchk_evt = 0, async_mchk_evt = 0, acc_valid = 0;
	logic instr_shadow_valid, data_shadow_valid;
	logic [11:0] maker_code_pin = 0;
	logic [19:0] version_number_code_pin = 0, sh_epn;
	logic [14:0] dbg_event = 0, ev;
	logic [21:0] sh_rpn;
	logic [7:0] sh_tid;
	logic [4:0] sh_wimge;
	logic [2:0] sh_perm;
	logic [33:0] exp_q[$];
	logic [31:0] r;
	logic [1:0] watchdog_reset_status, ck;
	logic [7:0] rw_offs[5] = '{OFF_MSW, OFF_DBC, OFF_CC0, OFF_CC1, OFF_TCR};
	int fails = 0, samples_checked = 0, seed = 99, i;

	crs_core_init DUT (.*);
	crs_pins_model pins (.*);

	// ----------------------------------------
	// Clock, compare and bus tasks
	// ----------------------------------------
	always #5 clk = ~clk;

	task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
			fails++;
		end
	endtask

	// Oldest read note against each accepted answer
	always @(posedge clk) if (s_rvalid && s_rready) check("rd", {s_rresp, s_rdata}, exp_q.pop_front());

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1;
		s_wvalid <= 1;
		do begin
			@(posedge clk);
			if (s_awvalid && s_awready) s_awvalid <= 0;
			if (s_wvalid && s_wready) s_wvalid <= 0;
		end while (!s_bvalid);
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] rs, input logic [31:0] d);
		exp_q.push_back({rs, d});
		s_araddr <= a;
		s_arvalid <= 1;
		do begin
			@(posedge clk);
			if (s_arvalid && s_arready) s_arvalid <= 0;
		end while (!s_rvalid);
	endtask

	// ----------------------------------------
	// Reset runs and audits
	// ----------------------------------------
	task automatic reset_run(input logic [1:0] k, input logic w, input logic p, input int cyc);
		kind_sel <= k;
		wd <= w;
		pu <= p;
		{maker_code_pin, version_number_code_pin} <= $random(seed);
		{cfg_user_attr_pin, cfg_endian_pin, cfg_ext_page_pin} <= 9'($random(seed));
		repeat (3) @(posedge clk);
		rst <= 1;
		repeat (cyc) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		kind_sel <= 0;
		wd <= 0;
		pu <= 0;
		ck = k;
	endtask

	// Dirty every cleared register, raise both machine checks and a random set of debug events
	task automatic fill;
		r = $random(seed);
		ev = 15'($random(seed));
		foreach (rw_offs[j]) wr(rw_offs[j], r);
		rd(OFF_CC1, RESP_OKAY, r);
		dbg_event <= ev;
		sync_mchk_evt <= 1;
		async_mchk_evt <= 1;
		@(posedge clk);
		dbg_event <= 0;
		sync_mchk_evt <= 0;
		async_mchk_evt <= 0;
		@(posedge clk);
		rd(OFF_DBS, RESP_OKAY, {2'h0, ck, 13'h0, ev});
		rd(OFF_ESR, RESP_OKAY, 32'h8000_0000);
		rd(OFF_MCS, RESP_OKAY, 32'h8000_0000);
	endtask

	task automatic audit;
		rd(OFF_MSW, RESP_OKAY, 32'h0);
		rd(OFF_DBC, RESP_OKAY, 32'h0);
		rd(OFF_DBS, RESP_OKAY, {2'h0, ck, 28'h0});
		rd(OFF_TCR, RESP_OKAY, 32'h0);
		rd(OFF_TSR, RESP_OKAY, {2'h0, watchdog_reset_status, 28'h0});
		rd(OFF_PVR, RESP_OKAY, {maker_code_pin, version_number_code_pin});
		rd(OFF_CC0, RESP_OKAY, 32'h0);
		rd(OFF_CC1, RESP_OKAY, 32'h0);
		rd(OFF_ESR, RESP_OKAY, 32'h0);
		rd(OFF_MCS, RESP_OKAY, 32'h0);
		rd(OFF_RCF, RESP_OKAY, {cfg_user_attr_pin, cfg_endian_pin, 23'h0, cfg_ext_page_pin});
		rd(8'h40, RESP_SLVERR, 32'h0);
		check("entry", {reset_fetch_addr, instr_shadow_valid, data_shadow_valid, sh_epn, sh_rpn,
			sh_size, sh_ts, sh_tid, sh_wimge, sh_perm}, {32'hffff_fffc, 2'h3, 20'hfffff,
			22'h3ffffc, 4'h1, 1'h0, 8'h00, 4'h5, cfg_endian_pin, 3'h5});
		check("cfg", {sh_extended_real_page, sh_user_attr, msw_out, soft_reset_req, wdog_reset_ctrl,
			core_cfg0_out, core_cfg1_out}, {cfg_ext_page_pin, cfg_user_attr_pin, 100'h0});
		// Fetch, read, write in the top page, then fetch below it
		for (int j = 0; j < 4; j++) begin
			acc_kind <= (j == 3) ? ACC_FETCH : 2'(j);
			acc_ea <= (j == 3) ? 32'hfffe_fffc : (j == 0) ? FETCH_RESET_EA :
				{20'hfffff, 12'($random(seed))};
			acc_valid <= 1;
			@(posedge clk);
			check("acc_ok", acc_ok, j < 2);
		end
		acc_valid <= 0;
		ctx_sync <= 1;
		@(posedge clk);
		ctx_sync <= 0;
		@(posedge clk);
		check("ctx", {instr_shadow_valid, data_shadow_valid}, 2'h0);
	endtask

	// ----------------------------------------
	// Main sequence, watchdog and verdict
	// ----------------------------------------
	task automatic give_verdict;
		$display("fails %0d samples_checked %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		reset_run(KIND_SYS, 0, 1, 20);
		watchdog_reset_status = 2'h0;
		audit();
		for (i = 0; i < 4; i++) begin
			fill();
			reset_run(i[1:0], i[0], 0, 4);
			watchdog_reset_status = i[0] ? r[31:30] : watchdog_reset_status;
			audit();
		end
		give_verdict();
	end

	initial begin
		#100000;
		fails++;
		give_verdict();
	end
endmodule
